// [dcap_link_partner.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// serial receiver standing in for the external converter
// ------------------------------------------------------------------
module dcap_link_partner (
	// link clocks made here
	output logic        bclk_o,
	output logic        lrclk_o,
	// serial data from the block
	input  wire logic   sdata_i,
	// last complete words received
	output logic [23:0] left_o,
	output logic [23:0] right_o
);
	// set at declaration so a clock edge at time zero cannot leave them unknown
	logic [4:0]  bit_cnt = 5'h00;       // bit slot within a half frame, 32 slots
	logic [23:0] shift   = 24'h00_0000; // word being assembled

	// bit clock, odd start offset so it never lines up with the core clock
	initial begin
		bclk_o = 1'b1;
		#37;
		forever #80 bclk_o = ~bclk_o;
	end

	// idle state before the first frame
	initial begin
		lrclk_o = 1'b0;
		left_o  = 24'h00_0000;
		right_o = 24'h00_0000;
	end

	// sync turns on a rising edge so the block sees it at the next fall;
	// data is taken on rising edges, half a period after it was launched
	always @(posedge bclk_o) begin
		if (bit_cnt < 5'h18)
			shift = {shift[22:0], sdata_i}; // msb first
		if (bit_cnt == 5'h17 && lrclk_o)
			left_o <= shift; // sync high carries the left slot
		if (bit_cnt == 5'h17 && !lrclk_o)
			right_o <= shift; // sync low carries the right slot
		if (bit_cnt == 5'h1f)
			lrclk_o <= ~lrclk_o; // 64 bit clocks per frame
		bit_cnt <= bit_cnt + 5'h01;
	end
endmodule

// [dcap_pkg.sv]
package dcap_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned DCAP_DW    = 24; // captured word width
	localparam int unsigned DCAP_STEPW = 9;  // program step index width
	localparam int unsigned DCAP_SELW  = 2;  // source select width
	localparam int unsigned DCAP_AW    = 10; // control-port location width
	localparam int unsigned DCAP_SLOTS = 4;  // number of capture slots

	// ------------------------------------------------------------------
	// control-port locations
	// ------------------------------------------------------------------
	localparam logic [9:0] DCAP_ADDR_HOST_CAP_ONE = 10'h105; // host capture one (261)
	localparam logic [9:0] DCAP_ADDR_HOST_CAP_TWO = 10'h106; // host capture two (262)
	localparam logic [9:0] DCAP_ADDR_SER_CAP_ONE  = 10'h107; // serial setup one (263)
	localparam logic [9:0] DCAP_ADDR_SER_CAP_TWO  = 10'h108; // serial setup two (264)

	// slot order: host one, host two, serial left, serial right
	localparam logic [9:0] DCAP_SLOT_ADDR [DCAP_SLOTS] = '{
		DCAP_ADDR_HOST_CAP_ONE, DCAP_ADDR_HOST_CAP_TWO,
		DCAP_ADDR_SER_CAP_ONE, DCAP_ADDR_SER_CAP_TWO};
	localparam int unsigned DCAP_SLOT_LEFT  = 2; // slot feeding the left slot
	localparam int unsigned DCAP_SLOT_RIGHT = 3; // slot feeding the right slot

	// ------------------------------------------------------------------
	// setup word field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned DCAP_SETUP_SEL_LSB  = 0;  // select in bits 1:0
	localparam int unsigned DCAP_SETUP_STEP_LSB = 2;  // step index in bits 10:2
	localparam int unsigned DCAP_DB_STEP_BIT    = 19; // one lsb here is a 3 dB step
	localparam logic [10:0] DCAP_SETUP_RST      = 11'h000;
	localparam logic [23:0] DCAP_VALUE_RST      = 24'h00_0000;
	localparam logic [21:0] DCAP_COEF_UNITY     = 22'h10_0000; // 1.0 in 2.20

	// ------------------------------------------------------------------
	// trap indexes of the default program
	// ------------------------------------------------------------------
	localparam logic [8:0] DCAP_TRAP_MAIN_RMS_DB   = 9'h09a; // 154, log level select
	localparam logic [8:0] DCAP_TRAP_SUB_GAIN      = 9'h1ef; // 495, coefficient select
	localparam logic [8:0] DCAP_TRAP_LOOK_LEFT     = 9'h0a5; // 165, data select
	localparam logic [8:0] DCAP_TRAP_LOOK_RIGHT    = 9'h0b2; // 178, data select
	localparam logic [8:0] DCAP_TRAP_SUB_XOVER0    = 9'h1b6; // 438, multiplier select
	localparam logic [8:0] DCAP_TRAP_SUB_XOVER1    = 9'h1bf; // 447
	localparam logic [8:0] DCAP_TRAP_SUB_XOVER2    = 9'h1c8; // 456
	localparam logic [8:0] DCAP_TRAP_LEFT_XOVER0   = 9'h063; // 99
	localparam logic [8:0] DCAP_TRAP_LEFT_XOVER1   = 9'h06c; // 108
	localparam logic [8:0] DCAP_TRAP_INTERP_LEFT   = 9'h0bf; // 191
	localparam logic [8:0] DCAP_TRAP_INTERP_RIGHT  = 9'h16a; // 362

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DCAP_SEL_MULT = 2'h0, // multiplier output, 1.23
		DCAP_SEL_DB   = 2'h1, // log level output, unsigned
		DCAP_SEL_DIN  = 2'h2, // multiplier data input, 3.21
		DCAP_SEL_COEF = 2'h3  // multiplier coefficient input, 2.20
	} dcap_sel_e;

	typedef enum logic {
		DCAP_H_IDLE = 1'h0,
		DCAP_H_BUSY = 1'h1
	} dcap_hand_e;

	typedef struct packed {
		logic [8:0] step; // program step to trap
		dcap_sel_e  sel;  // core register to take
	} dcap_setup_s;

	typedef struct packed {
		logic [23:0] mult_out;
		logic [23:0] log_level_output;
		logic [23:0] multiplier_data_in;
		logic [23:0] multiplier_coef_in;
	} dcap_src_s;

endpackage

// [dcap_slot.sv]
`timescale 1ns/10ps
module dcap_slot (
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 clk_en_i,
	// setup write
	input  wire logic                 setup_we_i,
	input  wire dcap_pkg::dcap_setup_s setup_i,
	// core side
	input  wire logic                 step_valid_i,
	input  wire logic [8:0]           program_step_index_i,
	input  wire dcap_pkg::dcap_src_s  src_i,
	// results
	output dcap_pkg::dcap_setup_s     setup_o,
	output logic [23:0]               value_o,
	output logic                      hit_o
);
	import dcap_pkg::*;

	dcap_setup_s next_setup; // programmed trap
	logic [23:0] next_value; // latched sample
	logic        next_hit;   // one-cycle update marker
	logic        match;      // trap step reached
	logic [23:0] picked;     // selected core register

	// ------------------------------------------------------------------
	// source select and trap
	// ------------------------------------------------------------------
	// the word is kept raw; the numeric format follows from the source
	always_comb begin
		case (setup_o.sel)
			DCAP_SEL_MULT: picked = src_i.mult_out;
			DCAP_SEL_DB:   picked = src_i.log_level_output; // R6
			DCAP_SEL_DIN:  picked = src_i.multiplier_data_in;
			DCAP_SEL_COEF: picked = src_i.multiplier_coef_in; // R1
			default:       picked = src_i.mult_out;
		endcase
	end
	// R13

	assign match = step_valid_i && (program_step_index_i == setup_o.step);

	always_comb begin
		next_setup = setup_o;
		next_value = value_o;
		next_hit   = 1'b0;
		if (setup_we_i) begin
			next_setup = setup_i; // R2
		end
		if (match) begin
			next_value = picked; // R14
			next_hit   = 1'b1;
		end
		// otherwise the last sample stands untouched R17
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			setup_o <= dcap_setup_s'(DCAP_SETUP_RST);
			value_o <= DCAP_VALUE_RST;
			hit_o   <= 1'b0;
		end else if (clk_en_i) begin
			setup_o <= next_setup;
			value_o <= next_value;
			hit_o   <= next_hit;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_trap_latch: assert property ( // R14
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && match |=> value_o == $past(picked) && hit_o)
		else $error("capture missed its trap step");

	a_coef_source: assert property ( // R1
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && match && setup_o.sel == DCAP_SEL_COEF
		|=> value_o == $past(src_i.multiplier_coef_in))
		else $error("coefficient select took wrong source");

	a_db_source: assert property ( // R6
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && match && setup_o.sel == DCAP_SEL_DB
		|=> value_o == $past(src_i.log_level_output))
		else $error("log level select took wrong source");

	a_value_hold: assert property ( // R17
		@(posedge ref_clk_i) disable iff (!nrst_i)
		!(clk_en_i && match) |=> $stable(value_o))
		else $error("captured value moved without a trap");

	a_setup_write: assert property ( // R2
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && setup_we_i |=> setup_o == $past(setup_i))
		else $error("setup word not stored");

endmodule

// [dcap_top.sv]
// What this block does
// R1: coefficient select yields 2.20, unity is defined
// R2: setup word is step index then select
// R3: locations 261 and 262 read host captures
// R4: serial captures stream out without host reads
// R5: serial one left slot, two right slot
// R6: log select yields unsigned level, bit19 3dB
// R7: step 154 log select reaches main rms
// R8: step 495 coefficient select reaches sub gain
// R9: steps 165/178 data select reach look-ahead
// R10: steps 438/447/456 reach sub crossover outputs
// R11: steps 99/108 reach left crossover outputs
// R12: steps 191/362 reach interpolator inputs
// R13: select codes pick multiplier, log, data, coefficient
// R14: latch source when program step equals count
// R15: serial out follows input frame sync, bit clock
// R16: host writes serial setups at 263, 264
// R17: captured value holds until next trap
`timescale 1ns/10ps
module dcap_top (
	// clock, reset and enable
	input  wire logic                 ref_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 clk_en_i,
	// core side
	input  wire logic                 step_valid_i,
	input  wire logic [8:0]           program_step_index_i,
	input  wire dcap_pkg::dcap_src_s  core_src_i,
	// control port
	input  wire logic                 ctl_wr_i,
	input  wire logic                 ctl_rd_i,
	input  wire logic [9:0]           ctl_addr_i,
	input  wire logic [23:0]          ctl_wdata_i,
	output logic [23:0]               ctl_rdata_o,
	output logic                      ctl_rvalid_o,
	// serial link
	input  wire logic                 bclk_i,
	input  wire logic                 lrclk_i,
	output logic                      capture_serial_out_o
);
	import dcap_pkg::*;

	// ------------------------------------------------------------------
	// capture slots
	// ------------------------------------------------------------------
	dcap_setup_s slot_setup [DCAP_SLOTS]; // programmed traps
	logic [23:0] slot_value [DCAP_SLOTS]; // latched samples
	logic        slot_hit   [DCAP_SLOTS]; // update markers
	dcap_setup_s wr_setup;                // setup field of a written word

	assign wr_setup = dcap_setup_s'(ctl_wdata_i[10:0]); // R2

	// any step 0 to 511 may be trapped, so every default-program point is
	// reachable: rms level R7, sub gain R8, look-ahead R9, sub crossover R10,
	// left crossover R11, interpolator inputs R12
	generate
		for (genvar g = 0; g < DCAP_SLOTS; g++) begin : g_slot
			dcap_slot u_slot (
				.ref_clk_i            (ref_clk_i),
				.nrst_i               (nrst_i),
				.clk_en_i             (clk_en_i),
				.setup_we_i           (ctl_wr_i && ctl_addr_i == DCAP_SLOT_ADDR[g]), // R16
				.setup_i              (wr_setup),
				.step_valid_i         (step_valid_i),
				.program_step_index_i (program_step_index_i),
				.src_i                (core_src_i),
				.setup_o              (slot_setup[g]),
				.value_o              (slot_value[g]),
				.hit_o                (slot_hit[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// control-port read
	// ------------------------------------------------------------------
	logic [23:0] next_rdata;  // read data for the next cycle
	logic        next_rvalid; // read answer strobe

	// host-capture locations return samples; serial setups read back
	always_comb begin
		next_rdata  = ctl_rdata_o;
		next_rvalid = 1'b0;
		if (ctl_rd_i) begin
			next_rvalid = 1'b1;
			case (ctl_addr_i)
				DCAP_ADDR_HOST_CAP_ONE: next_rdata = slot_value[0]; // R3
				DCAP_ADDR_HOST_CAP_TWO: next_rdata = slot_value[1]; // R3
				DCAP_ADDR_SER_CAP_ONE:  next_rdata = {13'h0000, slot_setup[DCAP_SLOT_LEFT]};
				DCAP_ADDR_SER_CAP_TWO:  next_rdata = {13'h0000, slot_setup[DCAP_SLOT_RIGHT]};
				default:                next_rdata = DCAP_VALUE_RST; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_rdata_o  <= DCAP_VALUE_RST;
			ctl_rvalid_o <= 1'b0;
		end else if (clk_en_i) begin
			ctl_rdata_o  <= next_rdata;
			ctl_rvalid_o <= next_rvalid;
		end
	end

	// ------------------------------------------------------------------
	// hand-off to the link domain
	// ------------------------------------------------------------------
	// toggle request with acknowledge: the holding words stay still while
	// busy, so the link side copies them without tearing a sample
	dcap_hand_e  hand, next_hand;              // hand-off state
	logic        pend, next_pend;              // new sample waiting
	logic        req, next_req;                // request toggle
	logic [23:0] hold_left, next_hold_left;    // word for the left slot
	logic [23:0] hold_right, next_hold_right;  // word for the right slot
	logic        ack_meta, ack_sync;           // acknowledge synchroniser
	logic        ack;                          // link-side acknowledge toggle
	logic        new_sample;                   // a serial slot just trapped

	assign new_sample = slot_hit[DCAP_SLOT_LEFT] || slot_hit[DCAP_SLOT_RIGHT];

	always_comb begin
		next_hand       = hand;
		next_pend       = pend || new_sample; // a fresh trap is never lost
		next_req        = req;
		next_hold_left  = hold_left;
		next_hold_right = hold_right;
		case (hand)
			DCAP_H_IDLE: begin
				if (next_pend) begin
					// samples go out with no host involvement R4
					next_hold_left  = slot_value[DCAP_SLOT_LEFT];
					next_hold_right = slot_value[DCAP_SLOT_RIGHT];
					next_req        = !req;
					next_pend       = 1'b0;
					next_hand       = DCAP_H_BUSY;
				end
			end
			DCAP_H_BUSY: begin
				if (ack_sync == req) begin
					next_hand = DCAP_H_IDLE;
				end
			end
			default: next_hand = DCAP_H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hand       <= DCAP_H_IDLE;
			pend       <= 1'b0;
			req        <= 1'b0;
			hold_left  <= DCAP_VALUE_RST;
			hold_right <= DCAP_VALUE_RST;
			ack_meta   <= 1'b0;
			ack_sync   <= 1'b0;
		end else if (clk_en_i) begin
			hand       <= next_hand;
			pend       <= next_pend;
			req        <= next_req;
			hold_left  <= next_hold_left;
			hold_right <= next_hold_right;
			ack_meta   <= ack;
			ack_sync   <= ack_meta;
		end
	end

	// ------------------------------------------------------------------
	// link domain: serial capture output
	// ------------------------------------------------------------------
	// limitation: lrclk_i must already belong to the bit-clock domain;
	// it is not resynchronised, only compared with its value one bit
	// earlier, so a sync that moves off the bit clock tears a slot
	// runs on the falling bit clock so each bit is settled before the
	// receiver samples on the rising edge; left-justified, frame sync high
	// selects the left word, msb first, unused slot bits are zero
	logic        req_meta, req_sync;          // request synchroniser
	logic        next_ack;                    // acknowledge toggle
	logic [23:0] link_left, next_link_left;   // word being framed left
	logic [23:0] link_right, next_link_right; // word being framed right
	logic [23:0] shift, next_shift;           // remaining bits of the slot
	logic        lr_prev;                     // frame sync one bit earlier
	logic        next_sout;                   // next serial bit

	always_comb begin
		next_ack        = ack;
		next_link_left  = link_left;
		next_link_right = link_right;
		if (req_sync != ack) begin
			next_link_left  = hold_left;
			next_link_right = hold_right;
			next_ack        = req_sync;
		end
		if (lrclk_i != lr_prev) begin
			// slot boundary: load the word for this half frame R15
			next_sout  = lrclk_i ? link_left[23] : link_right[23]; // R5
			next_shift = lrclk_i ? {link_left[22:0], 1'b0} : {link_right[22:0], 1'b0};
		end else begin
			next_sout  = shift[23];
			next_shift = {shift[22:0], 1'b0};
		end
	end

	always_ff @(negedge bclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_meta             <= 1'b0;
			req_sync             <= 1'b0;
			ack                  <= 1'b0;
			link_left            <= DCAP_VALUE_RST;
			link_right           <= DCAP_VALUE_RST;
			shift                <= DCAP_VALUE_RST;
			lr_prev              <= 1'b0;
			capture_serial_out_o <= 1'b0;
		end else begin
			req_meta             <= req;
			req_sync             <= req_meta;
			ack                  <= next_ack;
			link_left            <= next_link_left;
			link_right           <= next_link_right;
			shift                <= next_shift;
			lr_prev              <= lrclk_i;
			capture_serial_out_o <= next_sout;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_read_host_one: assert property ( // R3
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && ctl_rd_i && ctl_addr_i == DCAP_ADDR_HOST_CAP_ONE
		|=> ctl_rvalid_o && ctl_rdata_o == $past(slot_value[0]))
		else $error("location 261 did not return capture one");

	a_read_host_two: assert property ( // R3
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && ctl_rd_i && ctl_addr_i == DCAP_ADDR_HOST_CAP_TWO
		|=> ctl_rvalid_o && ctl_rdata_o == $past(slot_value[1]))
		else $error("location 262 did not return capture two");

	a_read_once: assert property ( // R3
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && !ctl_rd_i |=> !ctl_rvalid_o)
		else $error("read answer stood longer than one cycle");

	a_setup_back: assert property ( // R16
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && ctl_rd_i && ctl_addr_i == DCAP_ADDR_SER_CAP_ONE
		|=> ctl_rdata_o == {13'h0000, $past(slot_setup[DCAP_SLOT_LEFT])})
		else $error("serial setup one did not read back");

	a_hold_busy: assert property ( // R4
		@(posedge ref_clk_i) disable iff (!nrst_i)
		hand == DCAP_H_BUSY |=> $stable(hold_left) && $stable(hold_right))
		else $error("holding words moved during hand-off");

	a_send_sample: assert property ( // R4
		@(posedge ref_clk_i) disable iff (!nrst_i)
		clk_en_i && hand == DCAP_H_IDLE && new_sample
		|=> hand == DCAP_H_BUSY && hold_left == $past(slot_value[DCAP_SLOT_LEFT]))
		else $error("serial sample not handed off");

	a_link_copy: assert property ( // R4
		@(negedge bclk_i) disable iff (!nrst_i)
		req_sync != ack
		|=> link_left == $past(hold_left) && link_right == $past(hold_right))
		else $error("link words not taken from the hand-off");

	a_left_slot: assert property ( // R5
		@(negedge bclk_i) disable iff (!nrst_i)
		lrclk_i && !lr_prev |=> capture_serial_out_o == $past(link_left[23]))
		else $error("left slot msb wrong");

	a_right_slot: assert property ( // R5
		@(negedge bclk_i) disable iff (!nrst_i)
		!lrclk_i && lr_prev ##1 lrclk_i == $past(lrclk_i)
		|-> capture_serial_out_o == $past(link_right[23])
		    && next_sout == $past(link_right[22]))
		else $error("right slot bits wrong");

	c_host_read: cover property (
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ctl_rvalid_o && $past(ctl_addr_i) == DCAP_ADDR_HOST_CAP_ONE);

	c_unity_coef: cover property ( // R1
		@(posedge ref_clk_i) disable iff (!nrst_i)
		slot_hit[1] && slot_setup[1].sel == DCAP_SEL_COEF
		&& slot_value[1][21:0] == DCAP_COEF_UNITY);

	c_rms_trap: cover property ( // R7
		@(posedge ref_clk_i) disable iff (!nrst_i)
		slot_hit[0] && slot_setup[0].step == DCAP_TRAP_MAIN_RMS_DB
		&& slot_setup[0].sel == DCAP_SEL_DB);

	c_hand_done: cover property (
		@(posedge ref_clk_i) disable iff (!nrst_i)
		hand == DCAP_H_BUSY ##1 hand == DCAP_H_IDLE);

	c_left_frame: cover property (
		@(negedge bclk_i) disable iff (!nrst_i)
		lrclk_i && !lr_prev && link_left != DCAP_VALUE_RST);

endmodule

// [dcap_top_tb_top.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// self-checking bench for the capture block
// ------------------------------------------------------------------
module dcap_top_tb_top;
	import dcap_pkg::*;

	// one ordinary case: location, trap step, source, captured word
	typedef struct packed {
		logic [9:0]  addr;
		logic [8:0]  step;
		dcap_sel_e   sel;
		logic [23:0] val;
	} dcap_row_s;

	localparam dcap_row_s ROWS [13] = '{
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_MAIN_RMS_DB, DCAP_SEL_DB, 24'h08_0000},
		'{DCAP_ADDR_HOST_CAP_TWO, DCAP_TRAP_SUB_GAIN, DCAP_SEL_COEF, 24'h40_0000},
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_LOOK_LEFT, DCAP_SEL_DIN, 24'h12_3454},
		'{DCAP_ADDR_HOST_CAP_TWO, DCAP_TRAP_LOOK_RIGHT, DCAP_SEL_DIN, 24'hf0_0f0c},
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_SUB_XOVER0, DCAP_SEL_MULT, 24'h7f_ffff},
		'{DCAP_ADDR_HOST_CAP_TWO, DCAP_TRAP_SUB_XOVER1, DCAP_SEL_MULT, 24'h80_0000},
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_SUB_XOVER2, DCAP_SEL_MULT, 24'h00_0001},
		'{DCAP_ADDR_HOST_CAP_TWO, DCAP_TRAP_LEFT_XOVER0, DCAP_SEL_MULT, 24'hc0_ffee},
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_LEFT_XOVER1, DCAP_SEL_MULT, 24'h3c_3c3c},
		'{DCAP_ADDR_HOST_CAP_TWO, DCAP_TRAP_INTERP_LEFT, DCAP_SEL_MULT, 24'h55_aa55},
		'{DCAP_ADDR_HOST_CAP_ONE, DCAP_TRAP_INTERP_RIGHT, DCAP_SEL_MULT, 24'haa_55aa},
		'{DCAP_ADDR_HOST_CAP_TWO, 9'h000, DCAP_SEL_COEF, {2'h0, DCAP_COEF_UNITY}},
		'{DCAP_ADDR_HOST_CAP_ONE, 9'h1ff, DCAP_SEL_DB, 24'h0f_ffff}
	};

	// ------------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------------
	logic        ref_clk    = 1'b0;
	logic        nrst       = 1'b0;
	logic        clk_en     = 1'b1;
	logic        step_valid = 1'b0;
	logic [8:0]  step_idx   = 9'h000;
	dcap_src_s   core_src   = '0;
	logic        ctl_wr     = 1'b0;
	logic        ctl_rd     = 1'b0;
	logic [9:0]  ctl_addr   = 10'h000;
	logic [23:0] ctl_wdata  = 24'h00_0000;
	logic [23:0] ctl_rdata;
	logic        ctl_rvalid;
	logic        bclk;
	logic        lrclk;
	logic        ser_out;
	logic [23:0] left_word;
	logic [23:0] right_word;
	int          fails       = 0; // mismatches seen
	int          comparisons = 0; // checks made

	// core clock, 100 ns period
	always #50 ref_clk = ~ref_clk;

	dcap_top dut (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .clk_en_i(clk_en),
		.step_valid_i(step_valid), .program_step_index_i(step_idx), .core_src_i(core_src),
		.ctl_wr_i(ctl_wr), .ctl_rd_i(ctl_rd), .ctl_addr_i(ctl_addr), .ctl_wdata_i(ctl_wdata),
		.ctl_rdata_o(ctl_rdata), .ctl_rvalid_o(ctl_rvalid),
		.bclk_i(bclk), .lrclk_i(lrclk), .capture_serial_out_o(ser_out)
	);

	dcap_link_partner link (
		.bclk_o(bclk), .lrclk_o(lrclk), .sdata_i(ser_out),
		.left_o(left_word), .right_o(right_word)
	);

	// ------------------------------------------------------------------
	// compares, bus cycles and helpers
	// ------------------------------------------------------------------
	task automatic chk24(input string what, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// setup word: step index above the two select bits
	function automatic logic [23:0] word(input logic [8:0] s, input dcap_sel_e sel);
		return {13'h0000, s, sel};
	endfunction

	// every field distinct, so a wrong select can never match by chance
	function automatic dcap_src_s build(input dcap_sel_e sel, input logic [23:0] val,
			input int i);
		dcap_src_s s;
		s.mult_out           = 24'h1a_0000 + 24'(i);
		s.log_level_output   = 24'h2b_0000 + 24'(i);
		s.multiplier_data_in = 24'h3c_0000 + 24'(i);
		s.multiplier_coef_in = 24'h4d_0000 + 24'(i);
		case (sel)
			DCAP_SEL_MULT: s.mult_out = val;
			DCAP_SEL_DB:   s.log_level_output = val;
			DCAP_SEL_DIN:  s.multiplier_data_in = val;
			default:       s.multiplier_coef_in = val;
		endcase
		return s;
	endfunction

	task automatic wr(input logic [9:0] a, input logic [23:0] d);
		@(negedge ref_clk);
		ctl_wr    = 1'b1;
		ctl_addr  = a;
		ctl_wdata = d;
		@(negedge ref_clk);
		ctl_wr = 1'b0;
	endtask

	// read, wait a bounded time for the answer, then see the pulse end
	task automatic rd(input string what, input logic [9:0] a, input logic [23:0] exp);
		int n;
		@(negedge ref_clk);
		ctl_rd   = 1'b1;
		ctl_addr = a;
		@(negedge ref_clk);
		ctl_rd = 1'b0;
		n = 0;
		while (ctl_rvalid !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		chk1("read answer", 1'b1, ctl_rvalid);
		chk24(what, exp, ctl_rdata);
		@(negedge ref_clk);
		chk1("read pulse end", 1'b0, ctl_rvalid);
	endtask

	// one program step; the index moves on so no stale match lingers
	task automatic trap(input logic v, input logic [8:0] s, input dcap_src_s src);
		@(negedge ref_clk);
		step_valid = v;
		step_idx   = s;
		core_src   = src;
		@(negedge ref_clk);
		step_valid = 1'b0;
		step_idx   = s + 9'h001;
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		rd("capture one at reset", DCAP_ADDR_HOST_CAP_ONE, DCAP_VALUE_RST);
		rd("setup one at reset", DCAP_ADDR_SER_CAP_ONE, 24'h00_0000);
		$display("test reset done");
		foreach (ROWS[i]) begin
			wr(ROWS[i].addr, word(ROWS[i].step, ROWS[i].sel));
			trap(1'b1, ROWS[i].step, build(ROWS[i].sel, ROWS[i].val, i));
			rd("table capture", ROWS[i].addr, ROWS[i].val);
		end
		$display("test table done");
		// wrong step, unqualified step and frozen clock must all leave it
		trap(1'b1, 9'h1fe, build(DCAP_SEL_DB, 24'h77_7777, 20));
		trap(1'b0, 9'h1ff, build(DCAP_SEL_DB, 24'h66_6666, 21));
		@(negedge ref_clk);
		clk_en = 1'b0;
		wr(DCAP_ADDR_SER_CAP_ONE, 24'h00_07ff);
		trap(1'b1, 9'h1ff, build(DCAP_SEL_DB, 24'h55_5555, 22));
		@(negedge ref_clk);
		clk_en = 1'b1;
		rd("held capture", DCAP_ADDR_HOST_CAP_ONE, ROWS[12].val);
		rd("frozen setup", DCAP_ADDR_SER_CAP_ONE, 24'h00_0000);
		rd("unmapped", 10'h109, 24'h00_0000);
		$display("test hold done");
		// serial slots trapped two cycles apart, then a few frames pass
		wr(DCAP_ADDR_SER_CAP_ONE, word(9'h01e, DCAP_SEL_MULT));
		wr(DCAP_ADDR_SER_CAP_TWO, word(9'h01f, DCAP_SEL_DIN));
		rd("serial setup", DCAP_ADDR_SER_CAP_TWO, word(9'h01f, DCAP_SEL_DIN));
		trap(1'b1, 9'h01e, build(DCAP_SEL_MULT, 24'ha5_c30f, 30));
		trap(1'b1, 9'h01f, build(DCAP_SEL_DIN, 24'h3c_96e1, 31));
		repeat (450) @(negedge ref_clk);
		chk24("left slot", 24'ha5_c30f, left_word);
		chk24("right slot", 24'h3c_96e1, right_word);
		$display("test serial done");
		test_done();
	end

	// the sequence needs about 600 core cycles; allow five times that
	initial begin
		#(3000 * 100);
		fails++;
		test_done();
	end
endmodule
